/* File: adc_seq_cfg.svh */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004

// Control register fields
`define B_CE            0
`define B_RUN           1
`define B_MODE          2
`define B_DIV_LO        3
`define B_DIV_HI        5
`define B_LEN           6
`define B_TRIG_LO       7
`define B_TRIG_HI       8
`define B_ONESHOT       9
`define B_TEST          10
`define B_ISS           11
`define CTRL_MASK       32'h0000_0fff

// Conversion clock counts
`define N1_TOTAL        7'd54
`define N1_SAMPLE       7'd11
`define N2_TOTAL        7'd66
`define N2_SAMPLE       7'd23

// Supply stabilization wait, system clocks
`define STAB_N1         6'd4
`define STAB_N1_DIV1    6'd2
`define STAB_N2         6'd58

// Comparator settling times
`define CLK_PERIOD_NS   8
`define SETTLE_FAST_NS  500
`define SETTLE_SLOW_NS  2000
`define SETTLE_FAST_CYC ((`SETTLE_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_SLOW_CYC ((`SETTLE_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define LAST_SLOT       2'd3
`endif

/* File: adc_seq_pkg.sv */
package adc_seq_pkg;

	typedef enum logic [1:0] {
		TRIG_SW,
		TRIG_HW_NOWAIT,
		TRIG_HW_WAIT,
		TRIG_RSVD
	} trig_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_TRIG,
		ST_STAB,
		ST_CONV
	} seq_state_t;

endpackage : adc_seq_pkg

/* File: conv_clk_div.sv */
module conv_clk_div (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [2:0] div_sel,
	output logic            tick
);

	logic [4:0] cnt_q;
	logic [4:0] last;

	always_comb begin
		case (div_sel)
			3'h0:    last = 5'h1f;
			3'h1:    last = 5'h0f;
			3'h2:    last = 5'h07;
			3'h3:    last = 5'h05;
			3'h4:    last = 5'h04;
			3'h5:    last = 5'h03;
			3'h6:    last = 5'h01;
			default: last = 5'h00;
		endcase
	end

	assign tick = run && (cnt_q == last);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 5'h00;
		end else if (!run || tick) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

endmodule : conv_clk_div

/* File: conv_timer.sv */
`include "adc_seq_cfg.svh"

module conv_timer (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	input  wire logic abort,
	input  wire logic tick,
	input  wire logic len_sel,
	output logic      active,
	output logic      sampling,
	output logic      done
);

	logic [6:0] cnt_q;
	logic       act_q;
	logic       done_q;
	logic [6:0] total;
	logic [6:0] samp;

	assign total    = len_sel ? `N2_TOTAL : `N1_TOTAL;
	assign samp     = len_sel ? `N2_SAMPLE : `N1_SAMPLE;
	assign active   = act_q;
	assign sampling = act_q && (cnt_q < samp);
	assign done     = done_q;

	// Counts divided clocks; completion is a one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q  <= 7'h00;
			act_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start || abort) begin
				cnt_q <= 7'h00;
				act_q <= start;
			end else if (act_q && tick) begin
				if (cnt_q == total - 7'h01) begin
					act_q  <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 7'h01;
				end
			end
		end
	end

endmodule : conv_timer

/* File: adc_conversion_sequencer.sv */
// The APB register port and the register addresses were left to the implementer.
`include "adc_seq_cfg.svh"

module adc_conversion_sequencer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hw_trigger,
	output logic             comparator_on,
	output logic             conv_busy,
	output logic             sampling,
	output logic             conv_done,
	output logic       [1:0] scan_slot
);

	////////////////////////////////////////////////////////////////
	// Bus slave
	logic [31:0] ctrl_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        run_q;
	logic        run_d;
	adc_seq_pkg::seq_state_t state_q;
	adc_seq_pkg::seq_state_t state_d;
	logic [1:0]  slot_q;
	logic [1:0]  slot_d;
	logic [5:0]  stab_q;
	logic [5:0]  stab_d;
	logic [7:0]  settle_q;
	logic [31:0] status;

	wire setup    = psel && !penable;
	wire access   = psel && penable && pready_q;
	wire hit_ctrl = paddr == `OFS_CTRL;
	wire hit_stat = paddr == `OFS_STATUS;
	wire wr_ctrl  = access && pwrite && hit_ctrl;
	wire no_wr    = !wr_ctrl;

	wire       ce_q     = ctrl_q[`B_CE];
	wire       scan_q   = ctrl_q[`B_MODE];
	wire [2:0] div_q    = ctrl_q[`B_DIV_HI:`B_DIV_LO];
	wire       len_q    = ctrl_q[`B_LEN];
	wire       oneshot  = ctrl_q[`B_ONESHOT];
	wire       fast_src = ctrl_q[`B_TEST] || !ctrl_q[`B_ISS];
	adc_seq_pkg::trig_mode_t mode;
	assign mode = adc_seq_pkg::trig_mode_t'(ctrl_q[`B_TRIG_HI:`B_TRIG_LO]);

	wire [7:0] settle_need = fast_src ? 8'(`SETTLE_FAST_CYC) : 8'(`SETTLE_SLOW_CYC);
	wire       settled     = settle_q >= settle_need;

	assign status = {24'h0, settled, (state_q == adc_seq_pkg::ST_STAB), slot_q,
		conv_busy, (state_q == adc_seq_pkg::ST_WAIT_TRIG), ce_q, run_q};
	wire [31:0] rd_mux = hit_ctrl ? {20'h0, ctrl_q[11:2], run_q, ce_q} : status;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !(hit_ctrl || hit_stat);
			if (setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Run bit lives in run_q; the copy in ctrl_q is never read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 32'h0;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata & `CTRL_MASK;
		end
	end

	// Settling monitor, reported so software can time its run write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q <= 8'h00;
		end else if (!ce_q) begin
			settle_q <= 8'h00;
		end else if (!settled) begin
			settle_q <= settle_q + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// Trigger synchroniser
	logic trig_s1_q;
	logic trig_s2_q;
	logic trig_s3_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
		end else begin
			trig_s1_q <= hw_trigger;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	wire trig = trig_s2_q && !trig_s3_q;

	////////////////////////////////////////////////////////////////
	// Sequencer
	logic tick;
	logic t_active;
	logic t_sampling;
	logic t_done;
	logic start;

	wire sw_set = wr_ctrl && pwdata[`B_RUN] && pwdata[`B_CE] && mode != adc_seq_pkg::TRIG_HW_WAIT
		&& state_q == adc_seq_pkg::ST_IDLE && !run_q;
	wire sw_clr = wr_ctrl && !pwdata[`B_RUN];
	wire hw_set = mode == adc_seq_pkg::TRIG_HW_WAIT && ce_q && trig && state_q == adc_seq_pkg::ST_IDLE;
	wire last_slot = !scan_q || slot_q == `LAST_SLOT;
	wire [5:0] stab_len = len_q ? `STAB_N2 : (div_q == 3'h7 ? `STAB_N1_DIV1 : `STAB_N1);

	always_comb begin
		state_d = state_q;
		run_d   = run_q;
		slot_d  = slot_q;
		stab_d  = stab_q;
		start   = 1'b0;
		case (state_q)
			adc_seq_pkg::ST_IDLE: begin
				if (hw_set) begin
					run_d   = 1'b1;
					slot_d  = 2'd0;
					stab_d  = stab_len;
					state_d = adc_seq_pkg::ST_STAB;
				end else if (run_q && mode == adc_seq_pkg::TRIG_SW) begin
					start   = 1'b1;
					state_d = adc_seq_pkg::ST_CONV;
				end else if (run_q && mode == adc_seq_pkg::TRIG_HW_NOWAIT) begin
					state_d = adc_seq_pkg::ST_WAIT_TRIG;
				end
			end
			adc_seq_pkg::ST_WAIT_TRIG: begin
				if (trig) begin
					start   = 1'b1;
					slot_d  = 2'd0;
					state_d = adc_seq_pkg::ST_CONV;
				end
			end
			adc_seq_pkg::ST_STAB: begin
				if (stab_q <= 6'd1) begin
					start   = 1'b1;
					state_d = adc_seq_pkg::ST_CONV;
				end else begin
					stab_d = stab_q - 6'd1;
				end
			end
			adc_seq_pkg::ST_CONV: begin
				if (t_done) begin
					if (!last_slot) begin
						slot_d = slot_q + 2'd1;
						start  = 1'b1;
					end else begin
						slot_d = 2'd0;
						if (!oneshot) begin
							start = 1'b1;
						end else if (mode == adc_seq_pkg::TRIG_HW_NOWAIT) begin
							state_d = adc_seq_pkg::ST_WAIT_TRIG;
						end else begin
							run_d   = 1'b0;
							state_d = adc_seq_pkg::ST_IDLE;
						end
					end
				end
			end
			default: begin
				state_d = adc_seq_pkg::ST_IDLE;
			end
		endcase
		// A trigger landing with a clear keeps the set
		if (sw_clr && !hw_set) begin
			run_d   = 1'b0;
			slot_d  = 2'd0;
			start   = 1'b0;
			state_d = adc_seq_pkg::ST_IDLE;
		end else if (sw_set) begin
			run_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= adc_seq_pkg::ST_IDLE;
			run_q   <= 1'b0;
			slot_q  <= 2'd0;
			stab_q  <= 6'd0;
		end else begin
			state_q <= state_d;
			run_q   <= run_d;
			slot_q  <= slot_d;
			stab_q  <= stab_d;
		end
	end

	conv_clk_div u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (t_active && !start),
		.div_sel (div_q),
		.tick    (tick)
	);

	conv_timer u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (start),
		.abort    (state_d != adc_seq_pkg::ST_CONV),
		.tick     (tick),
		.len_sel  (len_q),
		.active   (t_active),
		.sampling (t_sampling),
		.done     (t_done)
	);

	////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_on <= 1'b0;
			conv_busy     <= 1'b0;
			sampling      <= 1'b0;
			conv_done     <= 1'b0;
			scan_slot     <= 2'd0;
		end else begin
			comparator_on <= ce_q;
			conv_busy     <= t_active;
			sampling      <= t_sampling;
			conv_done     <= t_done;
			scan_slot     <= slot_q;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////
	// Checks
	logic [6:0] ticks_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ticks_q <= 7'h00;
		end else if (start) begin
			ticks_q <= 7'h00;
		end else if (tick) begin
			ticks_q <= ticks_q + 7'h01;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_enter_conv;
		run_q ##1 (state_q == adc_seq_pkg::ST_CONV);
	endsequence

	wire end_quiet = t_done && state_q == adc_seq_pkg::ST_CONV && no_wr && last_slot && oneshot;

	property p_sw_start;
		sw_set && mode == adc_seq_pkg::TRIG_SW |=> s_enter_conv;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("run not set by software");

	property p_sw_clear;
		sw_clr && !hw_set |=> !run_q && state_q == adc_seq_pkg::ST_IDLE && !t_active;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("run not cleared");

	property p_oneshot_select;
		end_quiet && !scan_q && mode != adc_seq_pkg::TRIG_HW_NOWAIT |=> !run_q;
	endproperty
	a_oneshot_select: assert property (p_oneshot_select) else $error("select one-shot kept run");

	property p_scan_hold;
		t_done && scan_q && slot_q != `LAST_SLOT && state_q == adc_seq_pkg::ST_CONV && no_wr
			|=> run_q && slot_q == $past(slot_q) + 2'd1;
	endproperty
	a_scan_hold: assert property (p_scan_hold) else $error("scan ended early");

	property p_nowait_keep;
		end_quiet && mode == adc_seq_pkg::TRIG_HW_NOWAIT |=> run_q && state_q == adc_seq_pkg::ST_WAIT_TRIG;
	endproperty
	a_nowait_keep: assert property (p_nowait_keep) else $error("no-wait one-shot cleared run");

	property p_hw_set;
		hw_set |=> run_q && state_q == adc_seq_pkg::ST_STAB;
	endproperty
	a_hw_set: assert property (p_hw_set) else $error("trigger did not set run");

	property p_wait_standby;
		mode == adc_seq_pkg::TRIG_HW_WAIT && sw_clr && !hw_set |=> state_q == adc_seq_pkg::ST_IDLE [*2];
	endproperty
	a_wait_standby: assert property (p_wait_standby) else $error("no standby after clear");

	property p_no_restab;
		t_done && state_q == adc_seq_pkg::ST_CONV && no_wr && !(last_slot && oneshot)
			|=> state_q == adc_seq_pkg::ST_CONV && t_active;
	endproperty
	a_no_restab: assert property (p_no_restab) else $error("stabilization wait repeated");

	property p_conv_len;
		t_done |-> ticks_q == (len_q ? `N2_TOTAL : `N1_TOTAL);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("wrong conversion length");

	property p_div1;
		t_active && !start && div_q == 3'h7 |-> tick;
	endproperty
	a_div1: assert property (p_div1) else $error("divide by one missed a tick");

	property p_select_slot;
		!scan_q |-> slot_q == 2'd0;
	endproperty
	a_select_slot: assert property (p_select_slot) else $error("select mode left slot 0");

endmodule : adc_conversion_sequencer

/* File: trig_source.sv */
////////////////////////////////////////////////////////////////////////////////
// Far-side trigger source: a rising edge after a programmable wait, then a short high level
module trig_source (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       fire,
	input  wire logic [7:0] delay,
	output logic            hw_trigger
);
	timeunit 1ns;
	timeprecision 1ps;

	initial hw_trigger = 1'b0;

	// Bench fires only after the previous conversion ended, so spacing always covers the work
	always @(posedge fire) begin
		repeat (delay) @(posedge pclk);
		if (presetn) begin
			hw_trigger <= 1'b1;
			repeat (4) @(posedge pclk);
		end
		hw_trigger <= 1'b0;
	end
endmodule : trig_source

/* File: tb_top.sv */
`include "adc_seq_cfg.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [7:0]  dly = 8'h00;
	logic        pready, pslverr, hw_trigger, comparator_on, conv_busy, sampling, conv_done;
	logic [1:0]  scan_slot;
	logic [32:0] expq[$];
	int          bad_count = 0, compares = 0, seed = 32'hb16e, bc, sc, dc, gc, n, m;
	int          dvt[8] = '{32, 16, 8, 6, 5, 4, 2, 1};
	logic        l;

	always #4 pclk = ~pclk;

	adc_conversion_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .hw_trigger, .comparator_on, .conv_busy, .sampling, .conv_done, .scan_slot);
	trig_source partner (.pclk, .presetn, .fire, .delay(dly), .hw_trigger);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] cw(logic ce, logic run, logic md, logic [2:0] dv, logic ln,
		logic [1:0] tr, logic os);
		return {22'h0, os, tr, ln, dv, md, run, ce};
	endfunction : cw

	task automatic chk(string nm, logic [32:0] s, logic [32:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic give_verdict();
		if (bad_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// Read results are noted here and compared by the monitor when they appear
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			expq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
			chk("read", {pslverr, prdata}, expq.pop_front());
	end

	// Clearing first keeps mode changes in the stopped state; 260 cycles covers the slow settle
	task automatic arm(logic [31:0] c);
		apb(1'b1, 12'h000, 32'h0000_0000, 33'h0);
		apb(1'b1, 12'h000, c & ~32'h0000_0002, 33'h0);
		repeat (260) @(posedge pclk);
		apb(1'b1, 12'h000, c, 33'h0);
	endtask : arm

	task automatic watch(int nd);
		bc = 0;
		sc = 0;
		dc = 0;
		gc = 0;
		for (int i = 0; i < 20000 && dc < nd; i++) begin
			@(posedge pclk);
			bc += (conv_busy === 1'b1);
			sc += (sampling === 1'b1);
			dc += (conv_done === 1'b1);
			gc += (bc > 0 && conv_busy !== 1'b1);
		end
		chk("done", 33'(dc), 33'(nd));
		repeat (3) @(posedge pclk);
	endtask : watch

	// Delay settles a cycle before the fire edge so the partner never reads a stale value
	task automatic pulse();
		dly <= 8'($random(seed)) & 8'h1f;
		@(posedge pclk);
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
	endtask : pulse

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		bad_count++;
		give_verdict();
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 33'h0);
		apb(1'b0, 12'h004, 32'h0, 33'h0);
		apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
		chk("ce_off", 33'(comparator_on), 33'h0);
		for (int d = 0; d < 8; d++) begin
			l = 1'($random(seed));
			arm(cw(1, 1, 0, 3'(d), l, 2'd0, 1));
			watch(1);
			chk("ce_on", 33'(comparator_on), 33'h1);
			n = l ? `N2_TOTAL : `N1_TOTAL;
			m = l ? `N2_SAMPLE : `N1_SAMPLE;
			chk("busy", 33'(bc >= (n - 1) * dvt[d] && bc <= (n + 1) * dvt[d]), 33'h1);
			chk("samp", 33'(sc >= (m - 1) * dvt[d] && sc <= (m + 1) * dvt[d]), 33'h1);
			apb(1'b0, 12'h000, 32'h0, {1'b0, cw(1, 0, 0, 3'(d), l, 2'd0, 1)});
		end
		arm(cw(1, 1, 1, 3'd7, 0, 2'd0, 1));
		watch(3);
		chk("slot", 33'(scan_slot), 33'h3);
		apb(1'b0, 12'h000, 32'h0, {1'b0, cw(1, 1, 1, 3'd7, 0, 2'd0, 1)});
		watch(1);
		apb(1'b0, 12'h000, 32'h0, {1'b0, cw(1, 0, 1, 3'd7, 0, 2'd0, 1)});
		arm(cw(1, 1, 0, 3'd0, 0, 2'd0, 0));
		repeat (100) @(posedge pclk);
		apb(1'b1, 12'h000, cw(1, 0, 0, 3'd0, 0, 2'd0, 0), 33'h0);
		repeat (4) @(posedge pclk);
		chk("stop", 33'(conv_busy), 33'h0);
		apb(1'b0, 12'h000, 32'h0, {1'b0, cw(1, 0, 0, 3'd0, 0, 2'd0, 0)});
		arm(cw(1, 1, 0, 3'd7, 0, 2'd1, 1));
		for (int t = 0; t < 2; t++) begin
			pulse();
			watch(1);
			chk("nowait", 33'(dc), 33'h1);
			apb(1'b0, 12'h000, 32'h0, {1'b0, cw(1, 1, 0, 3'd7, 0, 2'd1, 1)});
		end
		arm(cw(1, 0, 1, 3'd7, 0, 2'd2, 1));
		apb(1'b1, 12'h000, cw(1, 1, 1, 3'd7, 0, 2'd2, 1), 33'h0);
		repeat (3) @(posedge pclk);
		chk("refuse", 33'(conv_busy), 33'h0);
		apb(1'b0, 12'h000, 32'h0, {1'b0, cw(1, 0, 1, 3'd7, 0, 2'd2, 1)});
		pulse();
		watch(4);
		chk("scan", 33'(dc == 4 && gc <= 9), 33'h1);
		apb(1'b0, 12'h000, 32'h0, {1'b0, cw(1, 0, 1, 3'd7, 0, 2'd2, 1)});
		arm(cw(1, 0, 0, 3'd7, 1, 2'd2, 0));
		pulse();
		watch(2);
		apb(1'b1, 12'h000, cw(1, 0, 0, 3'd7, 1, 2'd2, 0), 33'h0);
		repeat (4) @(posedge pclk);
		chk("standby", 33'(conv_busy), 33'h0);
		pulse();
		watch(1);
		chk("retrig", 33'(dc), 33'h1);
		give_verdict();
	end
endmodule : tb_top
